// File: core/sadc_ctrl.sv
// Function
// - Each pair bit selects two single-ended inputs or an even-plus differential pair.
// - Unused pair and channel register bits read zero and ignore writes.
// - Three-bit select picks an input; differential pair measured when configured.
// - SAR clock is system clock divided by divider field plus one.
// - Gain field picks 0.5, 1, 2 or 4; configuration bit 2 reads zero.
// - Converter-on bit low means shutdown; high means active and accepting starts.
// - Normal track mode tracks continuously except while converting.
// - Done flag sets on completion; only a software zero write clears it.
// - Active bit is high during conversion; its fall at completion sets the done flag, but not its fall when switched off.
// - Writing one to active bit starts only with source 000; zero does nothing.
// - Source field picks software, timer 3, strobe edge, timer 2 or primary start.
// - Low-power mode non-strobe triggers track 3 SAR clocks then convert.
// - Low-power strobe mode tracks while strobe low, converts on rising edge.
// - Window-match flag sets on match and holds until software clears it.
// - Control register supports single-bit writes as well as byte access.
// - Single-ended results are unsigned 0x00 to 0xFF.
// - Differential results are two's complement 0x80 to 0x7F.
// - Conversion lasts at least 8 SAR clocks with active bit high.
// - Active bit fall at completion raises interrupt request, not at shutdown; result then readable.
module sadc_ctrl (
   input wire logic clock,
   input wire logic rst_b,
   input wire sadc_pkg::sadc_bus_t bus,
   output logic [7:0] rdata,
   input wire logic timer3_ovf,
   input wire logic timer2_ovf,
   input wire logic external_strobe,
   input wire logic primary_converter_start_bit,
   input wire logic window_match,
   input wire logic [7:0] sar_code,
   output sadc_pkg::sadc_mux_t mux,
   output logic [1:0] gain_field,
   output logic converter_on,
   output logic tracking,
   output logic sample_hold,
   output logic sar_clock_tick,
   output logic conv_irq
);
   logic [7:0] pair_q;
   logic [7:0] chan_q;
   logic [7:0] cfg_q;
   logic [7:0] result_q;
   logic on_q, tm_q, done_q, win_q;
   logic [2:0] src_q;
   sadc_pkg::sadc_state_t state_q, state_d;
   logic [3:0] phase_q;
   logic [1:0] t3_s, t2_s, st_s, pr_s;
   logic t3_d1, t2_d1, st_d1, pr_d1;
   logic t3_edge, t2_edge, st_rise, pr_edge;
   logic soft_start, trigger, tick, busy, conv_end;
   logic [7:0] ctl_cur, ctl_wr;
   logic ctl_write;
   logic sar_run;

   function automatic logic [7:0] bit_merge(input logic [7:0] cur, input logic [2:0] sel,
                                            input logic val);
      logic [7:0] r;
      r = cur;
      r[sel] = val;
      return r;
   endfunction

   // Bit writes only reach the control register; elsewhere they are dropped.
   function automatic logic reg_hit(input sadc_pkg::sadc_bus_t b, input logic [7:0] a);
      return b.wr && !b.bit_wr && (b.addr == a);
   endfunction

   function automatic logic is_strobe(input logic [2:0] src);
      return src == sadc_pkg::SRC_STROBE;
   endfunction

   assign ctl_cur = {on_q, tm_q, done_q, busy, src_q, win_q};
   assign ctl_write = bus.wr && (bus.addr == sadc_pkg::ADDR_CONV_CTL);
   // Bit writes merge one bit into the current value; byte writes replace it.
   assign ctl_wr = bus.bit_wr ? bit_merge(ctl_cur, bus.bit_sel, bus.wdata[0])
                              : bus.wdata;

   // Masked bits are dropped on write, so reads return zero there.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         pair_q <= sadc_pkg::RST_PAIR_CFG;
         chan_q <= sadc_pkg::RST_CHAN_SEL;
         cfg_q <= sadc_pkg::RST_CONV_CFG;
      end else begin
         if (reg_hit(bus, sadc_pkg::ADDR_PAIR_CFG)) begin
            pair_q <= bus.wdata & sadc_pkg::MASK_PAIR_CFG;
         end
         if (reg_hit(bus, sadc_pkg::ADDR_CHAN_SEL)) begin
            chan_q <= bus.wdata & sadc_pkg::MASK_CHAN_SEL;
         end
         if (reg_hit(bus, sadc_pkg::ADDR_CONV_CFG)) begin
            cfg_q <= bus.wdata & sadc_pkg::MASK_CONV_CFG;
         end
      end
   end

   // The active and done bits have their own owners; this keeps only the on bit, mode and source.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         on_q <= 1'b0;
         tm_q <= 1'b0;
         src_q <= 3'h0;
      end else if (ctl_write) begin
         on_q <= ctl_wr[sadc_pkg::CTL_ON];
         tm_q <= ctl_wr[sadc_pkg::CTL_TRACK];
         src_q <= ctl_wr[sadc_pkg::CTL_SRC_LO +: 3];
      end
   end

   // Completion wins over a software clear in the same cycle.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         done_q <= 1'b0;
      end else if (conv_end) begin
         done_q <= 1'b1;
      end else if (ctl_write && !ctl_wr[sadc_pkg::CTL_DONE]) begin
         done_q <= 1'b0;
      end
   end

   // As with done, a match in the same cycle as a clear leaves the flag set.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         win_q <= 1'b0;
      end else if (window_match) begin
         win_q <= 1'b1;
      end else if (ctl_write && !ctl_wr[sadc_pkg::CTL_WIN]) begin
         win_q <= 1'b0;
      end
   end

   // Two-stage synchronisers; only the second stage feeds the edge detectors.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         t3_s <= 2'b00;
         t2_s <= 2'b00;
         st_s <= 2'b00;
         pr_s <= 2'b00;
         t3_d1 <= 1'b0;
         t2_d1 <= 1'b0;
         st_d1 <= 1'b0;
         pr_d1 <= 1'b0;
      end else begin
         t3_s <= {t3_s[0], timer3_ovf};
         t2_s <= {t2_s[0], timer2_ovf};
         st_s <= {st_s[0], external_strobe};
         pr_s <= {pr_s[0], primary_converter_start_bit};
         t3_d1 <= t3_s[1];
         t2_d1 <= t2_s[1];
         st_d1 <= st_s[1];
         pr_d1 <= pr_s[1];
      end
   end

   assign t3_edge = t3_s[1] && !t3_d1;
   assign t2_edge = t2_s[1] && !t2_d1;
   assign st_rise = st_s[1] && !st_d1;
   assign pr_edge = pr_s[1] && !pr_d1;
   // A written zero to the active bit is simply not a start.
   assign soft_start = ctl_write && ctl_wr[sadc_pkg::CTL_BUSY] && (src_q == sadc_pkg::SRC_SOFT);

   // Sources 1xx all follow the primary converter's start, whatever the low bits.
   always_comb begin
      trigger = 1'b0;
      if (src_q[2]) begin
         trigger = pr_edge;
      end else begin
         case (src_q[1:0])
            2'b00: trigger = soft_start;
            2'b01: trigger = t3_edge;
            2'b10: trigger = st_rise;
            2'b11: trigger = t2_edge;
            default: trigger = 1'b0;
         endcase
      end
   end

   // The SAR clock stops as soon as the converter is switched off, even mid-conversion.
   assign sar_run = on_q && (state_q != sadc_pkg::SADC_IDLE);
   sadc_divider u_div (
      .clock(clock),
      .rst_b(rst_b),
      .run(sar_run),
      .div(cfg_q[sadc_pkg::CFG_DIV_LO +: 5]),
      .tick(tick)
   );

   always_comb begin
      state_d = state_q;
      case (state_q)
         sadc_pkg::SADC_IDLE: begin
            // Strobe mode in low power has tracked while low, so the edge converts at once.
            if (on_q && trigger) begin
               if (tm_q && !is_strobe(src_q)) begin
                  state_d = sadc_pkg::SADC_TRACK;
               end else begin
                  state_d = sadc_pkg::SADC_CONV;
               end
            end
         end
         sadc_pkg::SADC_TRACK: begin
            if (tick && (phase_q == sadc_pkg::TRACK_SAR_CLKS - 4'h1)) begin
               state_d = sadc_pkg::SADC_CONV;
            end
         end
         sadc_pkg::SADC_CONV: begin
            if (tick && (phase_q == sadc_pkg::CONV_SAR_CLKS - 4'h1)) begin
               state_d = sadc_pkg::SADC_IDLE;
            end
         end
         default: state_d = sadc_pkg::SADC_IDLE;
      endcase
      if (!on_q) begin
         state_d = sadc_pkg::SADC_IDLE;
      end
   end

   // Triggers are only looked at in idle, so a running conversion is never restarted.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         state_q <= sadc_pkg::SADC_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Phase counts SAR clocks within the current state and restarts on every change.
   always_ff @(posedge clock) begin
      if (!rst_b || state_d != state_q) begin
         phase_q <= 4'h0;
      end else if (tick) begin
         phase_q <= phase_q + 4'h1;
      end
   end

   // Active reads high from the edge after a start until the edge that ends it.
   assign busy = (state_q != sadc_pkg::SADC_IDLE);
   assign conv_end = on_q && (state_q == sadc_pkg::SADC_CONV) && (state_d == sadc_pkg::SADC_IDLE);

   // The analog SAR supplies a code already in the right format for the selected mode.
   // Software may overwrite the result; a finishing conversion takes priority.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         result_q <= sadc_pkg::RST_RESULT;
      end else if (conv_end) begin
         result_q <= sar_code;
      end else if (reg_hit(bus, sadc_pkg::ADDR_RESULT)) begin
         result_q <= bus.wdata;
      end
   end

   // The request rises on the same edge as the done flag and the result, so the result is already readable.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         conv_irq <= 1'b0;
      end else begin
         conv_irq <= conv_end;
      end
   end

   // An odd channel in a differential pair measures the whole pair.
   always_comb begin
      mux.diff = pair_q[chan_q[2:1]];
      mux.pos = mux.diff ? {chan_q[2:1], 1'b0} : chan_q[2:0];
      mux.neg = {chan_q[2:1], 1'b1};
      mux.neg_used = mux.diff;
   end

   assign gain_field = cfg_q[1:0];
   assign converter_on = on_q;
   assign sar_clock_tick = tick;
   assign sample_hold = on_q && (state_q == sadc_pkg::SADC_CONV);

   // Tracking is reported only while the converter is on.
   always_comb begin
      if (!on_q) begin
         tracking = 1'b0;
      end else if (!tm_q) begin
         tracking = (state_q != sadc_pkg::SADC_CONV);
      end else if (is_strobe(src_q)) begin
         tracking = (state_q == sadc_pkg::SADC_IDLE) && !st_s[1];
      end else begin
         tracking = (state_q == sadc_pkg::SADC_TRACK);
      end
   end

   // Reads have no side effects; flags change only on a write or an event.
   always_comb begin
      case (bus.addr)
         sadc_pkg::ADDR_PAIR_CFG: rdata = pair_q;
         sadc_pkg::ADDR_CHAN_SEL: rdata = chan_q;
         sadc_pkg::ADDR_CONV_CFG: rdata = cfg_q;
         sadc_pkg::ADDR_RESULT: rdata = result_q;
         sadc_pkg::ADDR_CONV_CTL: rdata = ctl_cur;
         default: rdata = 8'h00;
      endcase
   end
endmodule

// File: core/sadc_pkg.sv
package sadc_pkg;
   localparam logic [7:0] ADDR_PAIR_CFG = 8'hBA;
   localparam logic [7:0] ADDR_CHAN_SEL = 8'hBB;
   localparam logic [7:0] ADDR_CONV_CFG = 8'hBC;
   localparam logic [7:0] ADDR_RESULT = 8'hBE;
   localparam logic [7:0] ADDR_CONV_CTL = 8'hE8;
   localparam logic [7:0] RST_PAIR_CFG = 8'h00;
   localparam logic [7:0] RST_CHAN_SEL = 8'h00;
   localparam logic [7:0] RST_CONV_CFG = 8'hF8;
   localparam logic [7:0] RST_RESULT = 8'h00;
   localparam logic [7:0] RST_CONV_CTL = 8'h00;
   localparam logic [7:0] MASK_PAIR_CFG = 8'h0F;
   localparam logic [7:0] MASK_CHAN_SEL = 8'h07;
   localparam logic [7:0] MASK_CONV_CFG = 8'hFB;
   localparam int CTL_ON = 7;
   localparam int CTL_TRACK = 6;
   localparam int CTL_DONE = 5;
   localparam int CTL_BUSY = 4;
   localparam int CTL_SRC_LO = 1;
   localparam int CTL_WIN = 0;
   localparam int CFG_DIV_LO = 3;
   localparam logic [2:0] SRC_SOFT = 3'h0;
   localparam logic [2:0] SRC_TMR3 = 3'h1;
   localparam logic [2:0] SRC_STROBE = 3'h2;
   localparam logic [2:0] SRC_TMR2 = 3'h3;
   localparam logic [3:0] TRACK_SAR_CLKS = 4'h3;
   localparam logic [3:0] CONV_SAR_CLKS = 4'h8;
   localparam int SETTLE_NS = 800;
   localparam int SYS_CLK_MHZ = 20;
   localparam int SETTLE_CYCLES = (SETTLE_NS * SYS_CLK_MHZ + 999) / 1000;
   typedef enum logic [1:0] {
      SADC_IDLE = 2'b00,
      SADC_TRACK = 2'b01,
      SADC_CONV = 2'b10
   } sadc_state_t;
   typedef struct packed {
      logic wr;
      logic rd;
      logic bit_wr;
      logic [7:0] addr;
      logic [2:0] bit_sel;
      logic [7:0] wdata;
   } sadc_bus_t;
   typedef struct packed {
      logic [2:0] pos;
      logic [2:0] neg;
      logic diff;
      logic neg_used;
   } sadc_mux_t;
endpackage

// File: core/sadc_divider.sv
module sadc_divider (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic run,
   input wire logic [4:0] div,
   output logic tick
);
   logic [4:0] cnt_q;

   // The divider restarts whenever the converter is idle so every phase is whole.
   always_ff @(posedge clock) begin
      if (!rst_b || !run) begin
         cnt_q <= 5'h0_0;
      end else if (cnt_q >= div) begin
         cnt_q <= 5'h0_0;
      end else begin
         cnt_q <= cnt_q + 5'h0_1;
      end
   end

   assign tick = run && (cnt_q >= div);
endmodule

// File: verif/sadc_ctrl_chk.sv
module sadc_ctrl_chk (
   input wire logic clock,
   input wire logic rst_b,
   input wire sadc_pkg::sadc_bus_t bus,
   input wire logic [7:0] rdata,
   input wire logic window_match,
   input wire sadc_pkg::sadc_mux_t mux,
   input wire logic converter_on,
   input wire logic tracking,
   input wire logic sample_hold,
   input wire logic sar_clock_tick,
   input wire logic conv_irq
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] pair_q;
   logic [2:0] chan_q;
   logic [4:0] div_q;
   logic [5:0] gap_q;
   logic seen_q;
   logic ctl;
   assign ctl = bus.addr == sadc_pkg::ADDR_CONV_CTL;
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         pair_q <= 4'h0;
         chan_q <= 3'h0;
         div_q <= 5'h1f;
      end else if (bus.wr && !bus.bit_wr) begin
         case (bus.addr)
            sadc_pkg::ADDR_PAIR_CFG: pair_q <= bus.wdata[3:0];
            sadc_pkg::ADDR_CHAN_SEL: chan_q <= bus.wdata[2:0];
            sadc_pkg::ADDR_CONV_CFG: div_q <= bus.wdata[7:3];
            default: ;
         endcase
      end
   end
   // Tick spacing is only judged inside one conversion; the interrupt pulse ends it.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         gap_q <= 6'h00;
         seen_q <= 1'b0;
      end else begin
         gap_q <= sar_clock_tick ? 6'h00 : gap_q + 6'h01;
         seen_q <= sar_clock_tick | (seen_q & ~conv_irq & converter_on);
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   sequence s_busy_fall;
      (ctl && rdata[7] && rdata[4] && !bus.wr) ##1 (ctl && !rdata[4]);
   endsequence
   sequence s_win_seen;
      window_match ##1 ctl;
   endsequence
   property p_unused_pair; bus.addr == sadc_pkg::ADDR_PAIR_CFG |-> rdata[7:4] == 4'h0; endproperty
   a_unused_pair: assert property (p_unused_pair) else $error("pair upper bits set");
   property p_unused_chan; bus.addr == sadc_pkg::ADDR_CHAN_SEL |-> rdata[7:3] == 5'h00; endproperty
   a_unused_chan: assert property (p_unused_chan) else $error("channel upper bits set");
   property p_cfg_bit2; bus.addr == sadc_pkg::ADDR_CONV_CFG |-> !rdata[2]; endproperty
   a_cfg_bit2: assert property (p_cfg_bit2) else $error("config bit 2 set");
   property p_done_fall; s_busy_fall |-> rdata[5]; endproperty
   a_done_fall: assert property (p_done_fall) else $error("done not set at busy fall");
   property p_done_hold;
      ctl && $past(ctl) && $past(rdata[5]) && $past(rst_b) && !$past(bus.wr) |-> rdata[5];
   endproperty
   a_done_hold: assert property (p_done_hold) else $error("done cleared by hardware");
   property p_off_quiet; !converter_on |-> !tracking && !sar_clock_tick; endproperty
   a_off_quiet: assert property (p_off_quiet) else $error("activity while off");
   property p_tick_busy; sar_clock_tick && ctl |-> rdata[4]; endproperty
   a_tick_busy: assert property (p_tick_busy) else $error("tick while idle");
   property p_tick_period; sar_clock_tick && seen_q |-> gap_q == {1'b0, div_q}; endproperty
   a_tick_period: assert property (p_tick_period) else $error("tick spacing wrong");
   property p_win; s_win_seen |-> rdata[0]; endproperty
   a_win: assert property (p_win) else $error("window flag not set");
   property p_mux_route;
      mux.diff == pair_q[chan_q[2:1]] && mux.pos == (mux.diff ? {chan_q[2:1], 1'b0} : chan_q)
         && (!mux.diff || mux.neg == {chan_q[2:1], 1'b1});
   endproperty
   a_mux_route: assert property (p_mux_route) else $error("mux route wrong");
   property p_irq_fall; s_busy_fall |-> conv_irq; endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("no request at busy fall");
   property p_track_normal;
      ctl && rdata[7] && !rdata[6] |-> tracking == !rdata[4];
   endproperty
   a_track_normal: assert property (p_track_normal) else $error("normal tracking wrong");
   property p_hold; sample_hold |-> !tracking; endproperty
   a_hold: assert property (p_hold) else $error("tracking while holding");
endmodule

bind sadc_ctrl sadc_ctrl_chk chk_i (.clock(clock), .rst_b(rst_b), .bus(bus), .rdata(rdata),
   .window_match(window_match), .mux(mux), .converter_on(converter_on), .tracking(tracking),
   .sample_hold(sample_hold), .sar_clock_tick(sar_clock_tick), .conv_irq(conv_irq));

// File: verif/sadc_sar_model.sv
module sadc_sar_model (
   input wire sadc_pkg::sadc_mux_t mux,
   output logic [7:0] sar_code
);
   timeunit 1ns;
   timeprecision 1ns;
   function automatic logic [7:0] level(input logic [2:0] ch);
      return {ch, 5'h08};
   endfunction
   // The wrapped difference of a pair is its two's complement code.
   assign sar_code = mux.diff ? level(mux.pos) - level(mux.neg) : level(mux.pos);
endmodule

// File: verif/test_sar_adc_8bit_control.sv
module test_sar_adc_8bit_control;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock;
   logic rst_b;
   sadc_pkg::sadc_bus_t bus;
   logic [7:0] rdata;
   logic [3:0] trig;
   logic win;
   logic [7:0] sar_code;
   sadc_pkg::sadc_mux_t mux;
   logic [1:0] gain_field;
   logic [2:0] src;
   logic [23:0] rows [7];
   int mismatches;
   int total_checks;
   int cyc;
   sadc_ctrl uut (.clock(clock), .rst_b(rst_b), .bus(bus), .rdata(rdata),
      .timer3_ovf(trig[0]), .timer2_ovf(trig[2]), .external_strobe(trig[1]),
      .primary_converter_start_bit(trig[3]), .window_match(win), .sar_code(sar_code),
      .mux(mux), .gain_field(gain_field), .converter_on(), .tracking(), .sample_hold(),
      .sar_clock_tick(), .conv_irq());
   sadc_sar_model model (.mux(mux), .sar_code(sar_code));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic b = 1'b0,
                     input logic [2:0] s = 3'h0);
      @(posedge clock);
      bus.wr <= 1'b1;
      bus.bit_wr <= b;
      bus.bit_sel <= s;
      bus.addr <= a;
      bus.wdata <= d;
      @(posedge clock);
      bus.wr <= 1'b0;
      bus.bit_wr <= 1'b0;
      bus.addr <= sadc_pkg::ADDR_CONV_CTL;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock);
      bus.addr <= a;
      @(posedge clock);
      chk(rdata, exp);
   endtask
   // For hardware sources a second trigger is fired mid-conversion; it must not start another one.
   task automatic conv(input logic [3:0] t, input int n);
      int c;
      c = 0;
      trig <= t;
      @(posedge clock);
      trig <= 4'h0;
      while (rdata[4] !== 1'b1 && c < 50) begin
         @(posedge clock);
         c++;
      end
      c = 0;
      while (rdata[4] === 1'b1 && c < 100) begin
         @(posedge clock);
         c++;
         trig <= (c == 4) ? t : 4'h0;
      end
      chk(8'(c), 8'(n));
      chk(8'(rdata[5]), 8'h01);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         mismatches++;
         test_done();
      end
   end
   initial begin
      bus = '0;
      bus.addr = sadc_pkg::ADDR_CONV_CTL;
      trig = 4'h0;
      win = 1'b0;
      rst_b = 1'b0;
      rows = '{24'hba_ff0f, 24'hbb_fd05, 24'hbc_fffb, 24'hbe_5a5a, 24'hc0_ff00, 24'hba_f000,
               24'hbc_1d19};
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      foreach (rows[i]) begin
         wr(rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16], rows[i][7:0]);
      end
      for (int g = 0; g < 4; g++) begin
         wr(sadc_pkg::ADDR_CONV_CFG, 8'h18 | 8'(g));
         rd(sadc_pkg::ADDR_CONV_CFG, 8'h18 | 8'(g));
         chk(8'(gain_field), 8'(g));
      end
      for (int m = 0; m < 2; m++) begin
         for (int s = 0; s < 5; s++) begin
            src = (s == 4) ? 3'h4 : 3'(s);
            wr(sadc_pkg::ADDR_CONV_CTL, {1'b1, 1'(m), 2'b00, src, 1'b0});
            if (s == 0) begin
               wr(sadc_pkg::ADDR_CONV_CTL, 8'h01, 1'b1, 3'h4);
            end
            conv(s == 0 ? 4'h0 : 4'h1 << (s - 1), (m == 1 && s != 2) ? 44 : 32);
            repeat (20) @(posedge clock);
            chk(8'(rdata[4]), 8'h00);
            rd(sadc_pkg::ADDR_RESULT, 8'ha8);
         end
      end
      wr(sadc_pkg::ADDR_CONV_CTL, 8'h92);
      rd(sadc_pkg::ADDR_CONV_CTL, 8'h82);
      wr(sadc_pkg::ADDR_CONV_CTL, 8'h12);
      @(posedge clock);
      trig <= 4'h1;
      @(posedge clock);
      trig <= 4'h0;
      repeat (6) @(posedge clock);
      rd(sadc_pkg::ADDR_CONV_CTL, 8'h02);
      wr(sadc_pkg::ADDR_PAIR_CFG, 8'h02);
      wr(sadc_pkg::ADDR_CHAN_SEL, 8'h03);
      repeat (sadc_pkg::SETTLE_CYCLES) @(posedge clock);
      wr(sadc_pkg::ADDR_CONV_CTL, 8'h80);
      wr(sadc_pkg::ADDR_CONV_CTL, 8'h01, 1'b1, 3'h4);
      conv(4'h0, 32);
      wr(sadc_pkg::ADDR_CONV_CTL, 8'h01, 1'b1, 3'h6);
      rd(sadc_pkg::ADDR_CONV_CTL, 8'he0);
      rd(sadc_pkg::ADDR_RESULT, 8'he0);
      @(posedge clock);
      win <= 1'b1;
      @(posedge clock);
      win <= 1'b0;
      rd(sadc_pkg::ADDR_CONV_CTL, 8'he1);
      wr(sadc_pkg::ADDR_CONV_CTL, 8'h00, 1'b1, 3'h5);
      rd(sadc_pkg::ADDR_CONV_CTL, 8'hc1);
      wr(sadc_pkg::ADDR_CONV_CTL, 8'h00, 1'b1, 3'h0);
      rd(sadc_pkg::ADDR_CONV_CTL, 8'hc0);
      @(posedge clock);
      rst_b <= 1'b0;
      @(posedge clock);
      rst_b <= 1'b1;
      rd(sadc_pkg::ADDR_PAIR_CFG, sadc_pkg::RST_PAIR_CFG);
      rd(sadc_pkg::ADDR_CHAN_SEL, sadc_pkg::RST_CHAN_SEL);
      rd(sadc_pkg::ADDR_CONV_CFG, sadc_pkg::RST_CONV_CFG);
      rd(sadc_pkg::ADDR_RESULT, sadc_pkg::RST_RESULT);
      rd(sadc_pkg::ADDR_CONV_CTL, sadc_pkg::RST_CONV_CTL);
      test_done();
   end
endmodule
